/* File: verilog/rbs_pkg.sv */
package rbs_pkg;

	// real-time clock rate that paces every hold and timeout
	localparam int RTC_HZ = 32768;

	// hold after the pin or watchdog cause, in rtc ticks
	localparam int PIN_HOLD_TICKS = 4;
	localparam int WDT_HOLD_TICKS = 4;

	// wake hold limit: 125 ms in rtc ticks
	localparam int HIB_MAX_MS = 125;
	localparam int HIB_MAX_TICKS = HIB_MAX_MS * RTC_HZ / 1000;
	localparam int HIB_W = 13;
	localparam logic [HIB_W-1:0] HIB_TICKS_RST = 13'h0800;

	// usb host wait: 10 s in rtc ticks
	localparam int USB_WAIT_S = 10;
	localparam int USB_WAIT_TICKS = USB_WAIT_S * RTC_HZ;
	localparam int USB_W = 19;

	localparam logic [3:0] MAX_RETRIES = 4'hA;

	// register map
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;

	// control field positions
	localparam int CTRL_HIB_LSB = 0;
	localparam int CTRL_PWR_BIT = 13;
	localparam int CTRL_USB_BIT = 14;
	localparam int CTRL_CDC_BIT = 15;
	localparam int CTRL_SAR_BIT = 16;

	// status field positions
	localparam int STAT_CAUSE_LSB = 0;
	localparam int STAT_SRC_LSB = 2;
	localparam int STAT_RETRY_LSB = 4;
	localparam int STAT_STATE_LSB = 8;

	// reset causes
	localparam logic [1:0] CAUSE_PIN = 2'h1;
	localparam logic [1:0] CAUSE_WDT = 2'h2;
	localparam logic [1:0] CAUSE_HIB = 2'h3;

	// strap codes {boot_strap_hi, boot_strap_lo}
	localparam logic [1:0] STRAP_NAND = 2'h3;
	localparam logic [1:0] STRAP_USB = 2'h1;
	localparam logic [1:0] STRAP_CARD = 2'h0;

	// boot source codes
	localparam logic [1:0] SRC_USB = 2'h0;
	localparam logic [1:0] SRC_NAND = 2'h1;
	localparam logic [1:0] SRC_CARD = 2'h2;

	typedef enum logic [5:0] {
		ST_HOLD = 6'h01,
		ST_SELECT = 6'h02,
		ST_MEDIA = 6'h04,
		ST_USB = 6'h08,
		ST_RUN = 6'h10,
		ST_HIBER = 6'h20
	} rbs_state_e;

endpackage

/* File: verilog/rbs_hold_if.sv */
`timescale 1ns/1ps
interface rbs_hold_if #(
	parameter int W = 13
);
	logic load;
	logic [W-1:0] load_val;
	logic tick;
	logic done;

	modport owner (
		output load,
		output load_val,
		output tick,
		input done
	);

	modport counter (
		input load,
		input load_val,
		input tick,
		output done
	);
endinterface

/* File: verilog/rbs_sync3.sv */
`timescale 1ns/1ps
module rbs_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// a bit changes only once the last two stages agree
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					q[i] <= RST_VAL[i];
				end else if (s2[i] == s3[i]) begin
					q[i] <= s3[i];
				end
			end
		end
	endgenerate
endmodule

/* File: verilog/rbs_hold_cnt.sv */
`timescale 1ns/1ps
module rbs_hold_cnt #(
	parameter int W = 13,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic core_clk,
	input wire logic rst_b,
	rbs_hold_if.counter hc
);
	logic [W-1:0] cnt;

	// down counter paced by rtc ticks; load wins over a tick
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= RST_VAL;
		end else if (hc.load) begin
			cnt <= hc.load_val;
		end else if (hc.tick && cnt != '0) begin
			cnt <= cnt - W'(1);
		end
	end

	assign hc.done = (cnt == '0);
endmodule

/* File: verilog/rbs_sequencer.sv */
//
// Behaviour
// RULE_01: three reset causes, then restart at boot
// RULE_02: external reset pin low forces reset
// RULE_03: pin reset held few rtc ticks after release
// RULE_04: watchdog expiry gives short rtc-timed reset
// RULE_05: wake reset held programmable 0 to 125 ms
// RULE_06: shared pins reset to pulled-up inputs
// RULE_07: stall pin reset to function with pull-up
// RULE_08: power-hold output low after reset
// RULE_09: oscillators run; phy, codec, sar suspended
// RULE_10: straps pick nand, usb or card boot
// RULE_11: failed nand or card boot falls to usb
// RULE_12: usb without host for 10 s restarts boot
// RULE_13: more than ten repeats enters hibernation
// RULE_14: media boot muxes pins; usb leaves pins
// RULE_15: stall and clock-out pins reset to function
// RULE_16: hold and retry timing paced by rtc clock
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
module rbs_sequencer #(
	parameter int PIN_COUNT = 32,
	parameter int STALL_IDX = 20,
	parameter int CLKOUT_IDX = 24,
	parameter logic [PIN_COUNT-1:0] NAND_PIN_MASK = 32'h0000_00FF,
	parameter logic [PIN_COUNT-1:0] CARD_PIN_MASK = 32'h0000_3F00,
	parameter int USB_WAIT_TICKS = rbs_pkg::USB_WAIT_TICKS
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ext_reset_in_n,
	input wire logic rtc_domain_clock,
	input wire logic wake_request_n,
	input wire logic boot_strap_lo,
	input wire logic boot_strap_hi,
	input wire logic watchdog_expire,
	input wire logic boot_ok,
	input wire logic boot_fail,
	input wire logic usb_connected,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic sys_reset_n,
	output logic boot_start,
	output logic [1:0] boot_source,
	output logic hibernate_out,
	output logic power_hold_out,
	output logic osc_rtc_en,
	output logic osc_main_en,
	output logic usb_phy_suspend,
	output logic codec_suspend,
	output logic sar_suspend,
	output logic [PIN_COUNT-1:0] pin_func,
	output logic [PIN_COUNT-1:0] pin_pullup
);
	localparam int HW = rbs_pkg::HIB_W;
	localparam int UW = rbs_pkg::USB_W;

	rbs_pkg::rbs_state_e state;
	logic [1:0] cause;
	logic [1:0] src;
	logic [3:0] retry;
	logic ext_q;
	logic rtc_q;
	logic wake_q;
	logic strap_hi_q;
	logic strap_lo_q;
	logic rtc_prev;
	logic rtc_tick;
	logic [HW-1:0] hib_ticks;
	logic ctrl_pwr;
	logic ctrl_usb;
	logic ctrl_cdc;
	logic ctrl_sar;
	logic wdt_hit;
	logic wake_hit;
	logic media_on;
	logic [PIN_COUNT-1:0] media_mask;

	rbs_hold_if #(.W(HW)) hold_if ();
	rbs_hold_if #(.W(UW)) usb_if ();

	// pins from outside pass the three-stage synchroniser
	rbs_sync3 #(
		.W(5),
		.RST_VAL(5'h17)
	) u_sync (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.d({ext_reset_in_n, rtc_domain_clock, wake_request_n,
			boot_strap_hi, boot_strap_lo}),
		.q({ext_q, rtc_q, wake_q, strap_hi_q, strap_lo_q})
	);

	// rtc rising edge becomes a one-cycle enable
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rtc_prev <= 1'b0;
			rtc_tick <= 1'b0;
		end else begin
			rtc_prev <= rtc_q;
			rtc_tick <= rtc_q & ~rtc_prev; // RULE_16
		end
	end

	assign wdt_hit = watchdog_expire && state != rbs_pkg::ST_HOLD;
	assign wake_hit = !wake_q && state == rbs_pkg::ST_HIBER;

	// reset hold counter
	assign hold_if.tick = rtc_tick; // RULE_16
	assign hold_if.load = !ext_q || wdt_hit || wake_hit;
	always_comb begin
		if (!ext_q) begin
			hold_if.load_val = HW'(rbs_pkg::PIN_HOLD_TICKS); // RULE_03
		end else if (wdt_hit) begin
			hold_if.load_val = HW'(rbs_pkg::WDT_HOLD_TICKS); // RULE_04
		end else begin
			hold_if.load_val = hib_ticks; // RULE_05
		end
	end

	rbs_hold_cnt #(
		.W(HW),
		.RST_VAL(HW'(rbs_pkg::PIN_HOLD_TICKS))
	) u_hold (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.hc(hold_if)
	);

	// usb host wait counter
	assign usb_if.tick = rtc_tick; // RULE_16
	assign usb_if.load = state == rbs_pkg::ST_SELECT
		|| state == rbs_pkg::ST_MEDIA;
	assign usb_if.load_val = UW'(USB_WAIT_TICKS);

	rbs_hold_cnt #(
		.W(UW),
		.RST_VAL('0)
	) u_usb (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.hc(usb_if)
	);

	// sequencing
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= rbs_pkg::ST_HOLD;
			cause <= rbs_pkg::CAUSE_PIN;
			retry <= 4'h0;
			src <= rbs_pkg::SRC_USB;
		end else if (!ext_q) begin
			state <= rbs_pkg::ST_HOLD; // RULE_02
			cause <= rbs_pkg::CAUSE_PIN; // RULE_01
			retry <= 4'h0;
			src <= rbs_pkg::SRC_USB;
		end else if (wdt_hit) begin
			state <= rbs_pkg::ST_HOLD; // RULE_04
			cause <= rbs_pkg::CAUSE_WDT; // RULE_01
			retry <= 4'h0;
			src <= rbs_pkg::SRC_USB;
		end else begin
			case (state)
				rbs_pkg::ST_HOLD: begin
					if (hold_if.done) begin
						state <= rbs_pkg::ST_SELECT; // RULE_01
					end
				end
				rbs_pkg::ST_SELECT: begin
					case ({strap_hi_q, strap_lo_q}) // RULE_10
						rbs_pkg::STRAP_NAND: begin
							src <= rbs_pkg::SRC_NAND;
							state <= rbs_pkg::ST_MEDIA;
						end
						rbs_pkg::STRAP_CARD: begin
							src <= rbs_pkg::SRC_CARD;
							state <= rbs_pkg::ST_MEDIA;
						end
						default: begin
							src <= rbs_pkg::SRC_USB;
							state <= rbs_pkg::ST_USB;
						end
					endcase
				end
				rbs_pkg::ST_MEDIA: begin
					if (boot_ok) begin
						state <= rbs_pkg::ST_RUN;
					end else if (boot_fail) begin
						src <= rbs_pkg::SRC_USB; // RULE_11
						state <= rbs_pkg::ST_USB;
					end
				end
				rbs_pkg::ST_USB: begin
					if (usb_connected) begin
						state <= rbs_pkg::ST_RUN;
					end else if (usb_if.done) begin
						if (retry == rbs_pkg::MAX_RETRIES) begin
							state <= rbs_pkg::ST_HIBER; // RULE_13
						end else begin
							retry <= retry + 4'h1; // RULE_13
							state <= rbs_pkg::ST_SELECT; // RULE_12
						end
					end
				end
				rbs_pkg::ST_RUN: begin
					state <= rbs_pkg::ST_RUN;
				end
				rbs_pkg::ST_HIBER: begin
					if (wake_hit) begin
						state <= rbs_pkg::ST_HOLD; // RULE_05
						cause <= rbs_pkg::CAUSE_HIB; // RULE_01
						retry <= 4'h0;
						src <= rbs_pkg::SRC_USB;
					end
				end
				default: begin
					state <= rbs_pkg::ST_HOLD;
				end
			endcase
		end
	end

	// control register; enables drop on every internal reset
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hib_ticks <= rbs_pkg::HIB_TICKS_RST;
		end else if (wr && addr == rbs_pkg::ADDR_CTRL) begin
			if (wdata[rbs_pkg::CTRL_HIB_LSB +: HW]
				> HW'(rbs_pkg::HIB_MAX_TICKS)) begin
				hib_ticks <= HW'(rbs_pkg::HIB_MAX_TICKS); // RULE_05
			end else begin
				hib_ticks <= wdata[rbs_pkg::CTRL_HIB_LSB +: HW];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_pwr <= 1'b0;
			ctrl_usb <= 1'b0;
			ctrl_cdc <= 1'b0;
			ctrl_sar <= 1'b0;
		end else if (hold_if.load || state == rbs_pkg::ST_HOLD) begin
			ctrl_pwr <= 1'b0; // RULE_08
			ctrl_usb <= 1'b0; // RULE_09
			ctrl_cdc <= 1'b0;
			ctrl_sar <= 1'b0;
		end else if (wr && addr == rbs_pkg::ADDR_CTRL) begin
			ctrl_pwr <= wdata[rbs_pkg::CTRL_PWR_BIT];
			ctrl_usb <= wdata[rbs_pkg::CTRL_USB_BIT];
			ctrl_cdc <= wdata[rbs_pkg::CTRL_CDC_BIT];
			ctrl_sar <= wdata[rbs_pkg::CTRL_SAR_BIT];
		end
	end

	// read port: data in the cycle after the strobe only
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= 32'h0000_0000;
			if (rd && addr == rbs_pkg::ADDR_CTRL) begin
				rdata[rbs_pkg::CTRL_HIB_LSB +: HW] <= hib_ticks;
				rdata[rbs_pkg::CTRL_PWR_BIT] <= ctrl_pwr;
				rdata[rbs_pkg::CTRL_USB_BIT] <= ctrl_usb;
				rdata[rbs_pkg::CTRL_CDC_BIT] <= ctrl_cdc;
				rdata[rbs_pkg::CTRL_SAR_BIT] <= ctrl_sar;
			end else if (rd && addr == rbs_pkg::ADDR_STATUS) begin
				rdata[rbs_pkg::STAT_CAUSE_LSB +: 2] <= cause;
				rdata[rbs_pkg::STAT_SRC_LSB +: 2] <= src;
				rdata[rbs_pkg::STAT_RETRY_LSB +: 4] <= retry;
				rdata[rbs_pkg::STAT_STATE_LSB +: 6] <= state;
			end
		end
	end

	// sequencer outputs
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sys_reset_n <= 1'b0;
			boot_start <= 1'b0;
			boot_source <= rbs_pkg::SRC_USB;
			hibernate_out <= 1'b0;
		end else begin
			sys_reset_n <= state != rbs_pkg::ST_HOLD; // RULE_03
			boot_start <= state == rbs_pkg::ST_SELECT; // RULE_01
			boot_source <= src;
			hibernate_out <= state == rbs_pkg::ST_HIBER; // RULE_13
		end
	end

	// power hold, oscillators and analog suspends
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			power_hold_out <= 1'b0;
			osc_rtc_en <= 1'b1;
			osc_main_en <= 1'b1;
			usb_phy_suspend <= 1'b1;
			codec_suspend <= 1'b1;
			sar_suspend <= 1'b1;
		end else begin
			power_hold_out <= ctrl_pwr; // RULE_08
			osc_rtc_en <= 1'b1; // RULE_09
			osc_main_en <= 1'b1; // RULE_09
			usb_phy_suspend <= !ctrl_usb; // RULE_09
			codec_suspend <= !ctrl_cdc;
			sar_suspend <= !ctrl_sar;
		end
	end

	// pin muxing: media pins only while a media boot owns them
	assign media_on = src != rbs_pkg::SRC_USB
		&& (state == rbs_pkg::ST_MEDIA || state == rbs_pkg::ST_RUN);
	assign media_mask = src == rbs_pkg::SRC_NAND
		? NAND_PIN_MASK : CARD_PIN_MASK;

	genvar p;
	generate
		for (p = 0; p < PIN_COUNT; p++) begin : g_pin
			localparam bit DEDICATED = p == STALL_IDX || p == CLKOUT_IDX;
			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					pin_func[p] <= DEDICATED; // RULE_15
					pin_pullup[p] <= 1'b1; // RULE_06
				end else if (DEDICATED) begin
					pin_func[p] <= 1'b1; // RULE_07
					pin_pullup[p] <= 1'b1; // RULE_07
				end else begin
					pin_func[p] <= media_on && media_mask[p]; // RULE_14
					pin_pullup[p] <= 1'b1; // RULE_06
				end
			end
		end
	endgenerate
endmodule

/* File: bench/rbs_seq_properties.sv */
`timescale 1ns/1ps
module rbs_seq_properties #(
	parameter int PIN_COUNT = 32
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ext_reset_in_n,
	input wire logic wake_request_n,
	input wire logic boot_strap_lo,
	input wire logic boot_strap_hi,
	input wire logic watchdog_expire,
	input wire logic sys_reset_n,
	input wire logic boot_start,
	input wire logic [1:0] boot_source,
	input wire logic hibernate_out,
	input wire logic power_hold_out,
	input wire logic osc_rtc_en,
	input wire logic osc_main_en,
	input wire logic usb_phy_suspend,
	input wire logic codec_suspend,
	input wire logic sar_suspend,
	input wire logic [PIN_COUNT-1:0] pin_func,
	input wire logic [PIN_COUNT-1:0] pin_pullup
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	pin_reset_a: assert property (
		!ext_reset_in_n [*7] |-> !sys_reset_n) else $error("pin reset lost");
	pin_hold_a: assert property (
		!ext_reset_in_n [*6] ##1 ext_reset_in_n |-> !sys_reset_n [*8])
		else $error("pin hold too short");
	wdt_reset_a: assert property (
		watchdog_expire && sys_reset_n |-> ##[1:3] !sys_reset_n)
		else $error("watchdog reset missing");
	osc_on_a: assert property (osc_rtc_en && osc_main_en)
		else $error("oscillator stopped");
	reset_outs_a: assert property (!sys_reset_n |->
		!power_hold_out && usb_phy_suspend && codec_suspend && sar_suspend)
		else $error("reset outputs wrong");
	pin_mode_a: assert property (
		&pin_pullup && pin_func[20] && pin_func[24])
		else $error("pin reset mode wrong");
	usb_pins_a: assert property (
		boot_source == 2'h0 |-> pin_func == 32'h0110_0000)
		else $error("usb boot moved pins");
	boot_pulse_a: assert property (boot_start |=> !boot_start)
		else $error("boot start too long");
	strap_nand_a: assert property (
		boot_start && boot_strap_hi && boot_strap_lo |-> ##[0:2]
		boot_source == 2'h1) else $error("nand strap not taken");
	hib_stay_a: assert property (
		(ext_reset_in_n && wake_request_n) [*5] ##0 hibernate_out
		|=> hibernate_out) else $error("left hibernation");
endmodule

bind rbs_sequencer rbs_seq_properties #(.PIN_COUNT(PIN_COUNT)) props_i (
	.core_clk, .rst_b, .ext_reset_in_n, .wake_request_n, .boot_strap_lo,
	.boot_strap_hi, .watchdog_expire, .sys_reset_n, .boot_start,
	.boot_source, .hibernate_out, .power_hold_out, .osc_rtc_en,
	.osc_main_en, .usb_phy_suspend, .codec_suspend, .sar_suspend,
	.pin_func, .pin_pullup);

/* File: bench/rbs_far_side.sv */
`timescale 1ns/1ps
module rbs_far_side (
	input wire logic core_clk,
	input wire logic boot_start,
	input wire logic [1:0] mode,
	output logic rtc_domain_clock = 1'b0,
	output logic boot_ok = 1'b0,
	output logic boot_fail = 1'b0
);
	logic [3:0] dly = 4'h0;

	// rtc sped up to 50 core cycles a period to keep runs short
	initial begin
		forever #100 rtc_domain_clock = ~rtc_domain_clock;
	end

	// media answers 8 cycles after each boot try; mode 1 pass, 2 fail
	always @(posedge core_clk) begin
		boot_ok <= dly == 4'h1 && mode == 2'h1;
		boot_fail <= dly == 4'h1 && mode == 2'h2;
		if (boot_start)
			dly <= 4'h8;
		else if (dly != 4'h0)
			dly <= dly - 4'h1;
	end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
	logic core_clk, rst_b, ext_reset_in_n, wake_request_n, watchdog_expire;
	logic boot_strap_lo, boot_strap_hi, usb_connected, wr, rd;
	logic rtc_domain_clock, boot_ok, boot_fail, sys_reset_n, boot_start;
	logic hibernate_out, power_hold_out, osc_rtc_en, osc_main_en;
	logic usb_phy_suspend, codec_suspend, sar_suspend;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, pin_func, pin_pullup;
	logic [1:0] mode, boot_source;
	int err_total = 0;
	int total_checks = 0;
	int n, k;

	rbs_sequencer #(.USB_WAIT_TICKS(20)) rbs_sequencer_i (
		.core_clk, .rst_b, .ext_reset_in_n, .rtc_domain_clock,
		.wake_request_n, .boot_strap_lo, .boot_strap_hi, .watchdog_expire,
		.boot_ok, .boot_fail, .usb_connected, .addr, .wdata, .wr, .rd,
		.rdata, .sys_reset_n, .boot_start, .boot_source, .hibernate_out,
		.power_hold_out, .osc_rtc_en, .osc_main_en, .usb_phy_suspend,
		.codec_suspend, .sar_suspend, .pin_func, .pin_pullup);

	rbs_far_side rbs_far_side_i (.core_clk, .boot_start, .mode,
		.rtc_domain_clock, .boot_ok, .boot_fail);

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask

	task rd_reg(input string what, input logic [3:0] a, input logic [31:0] e);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 chk(what, e, rdata);
	endtask

	task wait_sys(input logic lvl);
		n = 0;
		while (sys_reset_n !== lvl && n < 5000) begin
			@(posedge core_clk);
			#1 n++;
		end
		if (n >= 5000) begin
			chk("sys_reset_n wait", lvl, sys_reset_n);
			report_and_stop();
		end
	endtask

	task outs(input string what, input logic [3:0] e);
		chk(what, e, {power_hold_out, usb_phy_suspend, codec_suspend,
			sar_suspend});
	endtask

	initial begin
		rst_b = 1'b0;
		ext_reset_in_n = 1'b1;
		wake_request_n = 1'b1;
		{boot_strap_hi, boot_strap_lo} = 2'h3;
		{watchdog_expire, usb_connected, wr, rd} = 4'h0;
		addr = 4'h0;
		wdata = 32'h0;
		mode = 2'h2;
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		#1 chk("reset pins", 32'h0110_0000, pin_func);
		chk("pullups", 32'hFFFF_FFFF, pin_pullup);
		outs("reset outs", 4'h7);
		rd_reg("ctrl", 4'h0, 32'h0000_0800);
		rd_reg("unmapped", 4'h8, 32'h0);
		wr_reg(4'h0, 32'h0000_0002);
		usb_connected <= 1'b1;
		wait_sys(1'b1);
		repeat (2) @(posedge core_clk);
		#1 chk("nand pins", 32'h0110_00FF, pin_func);
		chk("nand src", 2'h1, boot_source);
		repeat (12) @(posedge core_clk);
		#1 chk("fallback src", 2'h0, boot_source);
		$display("test nand fallback done");

		wr_reg(4'h0, 32'h0001_E002);
		@(posedge core_clk);
		#1 outs("ctrl outs", 4'h8);
		watchdog_expire <= 1'b1;
		mode <= 2'h1;
		{boot_strap_hi, boot_strap_lo} <= 2'h0;
		@(posedge core_clk);
		watchdog_expire <= 1'b0;
		wait_sys(1'b0);
		outs("wdt outs", 4'h7);
		wait_sys(1'b1);
		repeat (2) @(posedge core_clk);
		#1 chk("card pins", 32'h0110_3F00, pin_func);
		repeat (12) @(posedge core_clk);
		rd_reg("wdt status", 4'h4, 32'h0000_100A);
		$display("test watchdog card done");

		{boot_strap_hi, boot_strap_lo} <= 2'h1;
		usb_connected <= 1'b0;
		ext_reset_in_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		ext_reset_in_n <= 1'b1;
		n = 0;
		k = 0;
		while (hibernate_out !== 1'b1 && n < 20000) begin
			@(posedge core_clk);
			#1 n++;
			if (boot_start === 1'b1)
				k++;
		end
		if (n >= 20000) begin
			chk("hibernate wait", 32'h1, hibernate_out);
			report_and_stop();
		end
		chk("boot tries", 32'd11, k);
		$display("test retries done");

		wake_request_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		wake_request_n <= 1'b1;
		wait_sys(1'b1);
		rd_reg("wake status", 4'h4, 32'h0000_0803);
		wr_reg(4'h0, 32'h0000_1FFF);
		rd_reg("hib clamp", 4'h0, 32'h0000_1000);
		$display("test wake done");
		report_and_stop();
	end
endmodule
